// *** inc/gyr_defs.svh ***
`ifndef GYR_DEFS_SVH
`define GYR_DEFS_SVH

// ---------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------
`define GYR_OFS_DIVIDER   8'h15
`define GYR_OFS_IRQ_CFG   8'h17
`define GYR_OFS_FLAGS     8'h1A
`define GYR_OFS_TEMP_H    8'h1B
`define GYR_OFS_TEMP_L    8'h1C
`define GYR_OFS_X_H       8'h1D
`define GYR_OFS_X_L       8'h1E
`define GYR_OFS_Y_H       8'h1F
`define GYR_OFS_Y_L       8'h20
`define GYR_OFS_Z_H       8'h21
`define GYR_OFS_Z_L       8'h22
`define GYR_OFS_POWER     8'h3E

// The burst pointer holds when its next value falls in this window.
`define GYR_PTR_HOLD_LO   8'h23
`define GYR_PTR_HOLD_HI   8'h3D

// ---------------------------------------------------------------------
// Field positions and masks
// ---------------------------------------------------------------------
`define GYR_CFG_ACTIVE_LOW  7
`define GYR_CFG_OPEN_DRAIN  6
`define GYR_CFG_LATCH       5
`define GYR_CFG_ANY_READ    4
`define GYR_CFG_CLK_RDY_EN  2
`define GYR_CFG_DATA_RDY_EN 0
`define GYR_CFG_WR_MASK     8'hF5
`define GYR_FLAG_CLK_RDY    2
`define GYR_FLAG_DATA_RDY   0
`define GYR_PWR_RESET       7

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define GYR_CFG_RESET       8'h00
`define GYR_FLAGS_RESET     3'h0
`define GYR_DIV_RESET       8'h00
`define GYR_PWR_RESET_VAL   7'h00
`define GYR_DEV_ADDR        7'h68

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define GYR_CLK_HZ          20000000
`define GYR_PULSE_US        50
`define GYR_PULSE_CYC  ((`GYR_PULSE_US * `GYR_CLK_HZ + 999999) / 1000000)

`endif

// *** inc/gyr_pkg.sv ***
package gyr_pkg;

  // Serial link byte engine states, one-hot.
  typedef enum logic [8:0] {
    LK_IDLE      = 9'h001,
    LK_ADDR      = 9'h002,
    LK_ADDR_ACK  = 9'h004,
    LK_PTR       = 9'h008,
    LK_PTR_ACK   = 9'h010,
    LK_WDATA     = 9'h020,
    LK_WDATA_ACK = 9'h040,
    LK_RDATA     = 9'h080,
    LK_RDATA_ACK = 9'h100
  } gyr_link_state_t;

  // One register access passed from the link to the core domain.
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } gyr_req_t;

  // One complete sample set from the filter.
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } gyr_sample_t;

  // Power and clock control as seen by the analog side.
  typedef struct packed {
    logic       sleep;
    logic [2:0] standby;
    logic [2:0] clk_sel;
  } gyr_power_t;

endpackage

// *** tb/gyr_host.sv ***
`include "gyr_defs.svh"
module gyr_host (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      pull_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------------
  // Serial master
  // -------------------------------------------------------------------
  localparam int         H = 1100;
  localparam logic [6:0] A = `GYR_DEV_ADDR;
  // The bus idles released, with SCL high and still between frames.
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  // Data moves well after the SCL fall so it is never read as START.
  task automatic bit_io(input logic b, output logic r);
    #200 pull_o = !b;
    #H scl_o = 1'b1;
    #H r = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic start();
    #200 pull_o = 1'b0;
    #H scl_o = 1'b1;
    #H pull_o = 1'b1;
    #H scl_o = 1'b0;
  endtask
  task automatic stop();
    #200 pull_o = 1'b1;
    #H scl_o = 1'b1;
    #H pull_o = 1'b0;
    #H;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // The last byte of a read is refused so the device lets go.
  task automatic recv(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
  task automatic wr(input logic [7:0] p, d, output logic ok);
    logic k0, k1, k2;
    start();
    send({A, 1'b0}, k0);
    send(p, k1);
    send(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask
  task automatic rd(input logic [7:0] p, input int n,
                    output logic [63:0] q, output logic ok);
    logic       k0, k1, k2;
    logic [7:0] b;
    q = '0;
    start();
    send({A, 1'b0}, k0);
    send(p, k1);
    start();
    send({A, 1'b1}, k2);
    for (int i = 0; i < n; i++) begin
      recv(i == n - 1, b);
      q = {q[55:0], b};
    end
    stop();
    ok = k0 & k1 & k2;
  endtask
endmodule

// *** tb/gyr_regs_bench.sv ***
`include "gyr_defs.svh"
`define CHK(a, e) begin \
  n_tests++; \
  if ((a) !== (e)) begin \
    err_total++; \
    $display("unexpected at %0t: %h vs %h", $time, a, e); \
  end \
end
module gyr_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import gyr_pkg::*;
  localparam logic [63:0] SMP = 64'h8001_7FFE_1234_FEDC;
  logic        clk, rst, lclk, scl, pull, sda_o, sda_oe_n;
  logic        tick, pll, irq, irq_oe_n;
  int          err_total, n_tests, cyc;
  logic [63:0] q;
  gyr_sample_t smp;
  gyr_power_t  pwr;
  // The data line has a pull-up: it is low only while someone pulls.
  wire logic   sda = (pull || !(sda_oe_n || sda_o)) ? 1'b0 : 1'b1;
  gyr_regs u_gyr_regs (.clk_i(clk), .rst_i(rst), .link_clk_i(lclk),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
    .sample_tick_i(tick), .sample_i(smp), .pll_ready_i(pll),
    .power_o(pwr), .irq_o(irq), .irq_oe_n_o(irq_oe_n));
  gyr_host u_gyr_host (.sda_i(sda), .scl_o(scl), .pull_o(pull));
  // Two unrelated clocks: core at 50 ns, link at 6 ns.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #1.7;
    forever #3 lclk = ~lclk;
  end
  // A hang is cut short well above the expected run length.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic tk();
    idle(1);
    tick = 1'b1;
    idle(1);
    tick = 1'b0;
  endtask
  task automatic w(input logic [7:0] a, d);
    logic ok;
    u_gyr_host.wr(a, d, ok);
    `CHK(ok, 1'b1)
  endtask
  task automatic r(input logic [7:0] a, input int n);
    logic ok;
    u_gyr_host.rd(a, n, q, ok);
    `CHK(ok, 1'b1)
  endtask
  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_reset();
    r(`GYR_OFS_POWER, 1);
    `CHK(q[7:0], 8'h00)
    `CHK(pwr.clk_sel, 3'h0)
    `CHK(irq, 1'b0)
  endtask
  task automatic t_pulse();
    w(`GYR_OFS_IRQ_CFG, 8'h01);
    tk();
    idle(5);
    `CHK(irq, 1'b1)
    idle(900);
    `CHK(irq, 1'b1)
    idle(120);
    `CHK(irq, 1'b0)
    r(`GYR_OFS_FLAGS, 1);
    `CHK(q[7:0], 8'h01)
    r(`GYR_OFS_FLAGS, 1);
    `CHK(q[7:0], 8'h00)
    r(`GYR_OFS_TEMP_H, 8);
    `CHK(q, SMP)
  endtask
  task automatic t_latch();
    w(`GYR_OFS_IRQ_CFG, 8'hF1);
    tk();
    idle(1100);
    `CHK({irq, irq_oe_n}, 2'h0)
    r(`GYR_OFS_X_H, 1);
    `CHK({irq, irq_oe_n}, 2'h3)
    r(`GYR_OFS_FLAGS, 1);
    `CHK(q[7:0], 8'h00)
  endtask
  task automatic t_divider();
    w(`GYR_OFS_IRQ_CFG, 8'h20);
    tk();
    r(`GYR_OFS_FLAGS, 1);
    `CHK(q[7:0], 8'h00)
    w(`GYR_OFS_DIVIDER, 8'h02);
    w(`GYR_OFS_IRQ_CFG, 8'h21);
    tk();
    tk();
    idle(5);
    `CHK(irq, 1'b0)
    tk();
    idle(5);
    `CHK(irq, 1'b1)
    r(`GYR_OFS_FLAGS, 1);
    `CHK(q[7:0], 8'h01)
  endtask
  task automatic t_clock();
    w(`GYR_OFS_IRQ_CFG, 8'h05);
    w(`GYR_OFS_POWER, 8'h01);
    `CHK(pwr.clk_sel, 3'h1)
    r(`GYR_OFS_FLAGS, 1);
    `CHK(q[7:0], 8'h00)
    idle(1);
    pll = 1'b1;
    idle(10);
    r(`GYR_OFS_FLAGS, 1);
    `CHK(q[7:0], 8'h04)
    w(`GYR_OFS_POWER, 8'h7D);
    `CHK(pwr, 7'h7D)
    tk();
    r(`GYR_OFS_FLAGS, 1);
    `CHK(q[7:0], 8'h04)
    for (int i = 0; i < 3; i++) begin
      w(`GYR_OFS_POWER, 8'h20 >> i);
      `CHK(pwr.standby, 3'h4 >> i)
    end
    // Z is in standby now: it must keep the old sample while others move.
    idle(1);
    smp = ~SMP;
    repeat (3) tk();
    r(`GYR_OFS_TEMP_H, 8);
    `CHK(q, {~SMP[63:16], SMP[15:0]})
  endtask
  task automatic t_soft();
    w(`GYR_OFS_POWER, 8'h80);
    `CHK(pwr, 7'h00)
    r(`GYR_OFS_IRQ_CFG, 1);
    `CHK(q[7:0], 8'h00)
    r(`GYR_OFS_TEMP_H, 2);
    `CHK(q[15:0], 16'h0000)
  endtask
  // Main sequence: reset for 16 cycles, then each scenario in turn.
  initial begin
    rst = 1'b1;
    tick = 1'b0;
    pll = 1'b0;
    smp = SMP;
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    idle(16);
    rst = 1'b0;
    idle(10);
    t_reset();
    t_pulse();
    t_latch();
    t_divider();
    t_clock();
    t_soft();
    give_verdict();
  end
endmodule

// *** verilog/gyr_regs.sv ***
`include "gyr_defs.svh"

module gyr_regs #(
  parameter logic [6:0] DEV_ADDR = `GYR_DEV_ADDR
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 link_clk_i,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe_n_o,
  input  wire logic                 sample_tick_i,
  input  wire gyr_pkg::gyr_sample_t sample_i,
  input  wire logic                 pll_ready_i,
  output gyr_pkg::gyr_power_t       power_o,
  output logic                      irq_o,
  output logic                      irq_oe_n_o
);
  import gyr_pkg::*;

  localparam int PULSE_CYC = `GYR_PULSE_CYC;
  localparam int PULSE_M1  = `GYR_PULSE_CYC - 1;

  // Next burst pointer; it stops short of the reserved window.
  function automatic logic [7:0] ptr_next(input logic [7:0] p);
    logic [7:0] n;
    n = p + 8'h01;
    if (n >= `GYR_PTR_HOLD_LO && n <= `GYR_PTR_HOLD_HI) begin
      ptr_next = p;
    end else begin
      ptr_next = n;
    end
  endfunction

  // ---------------------------------------------------------------------
  // Link domain: pin synchronisers and byte engine
  // ---------------------------------------------------------------------
  logic [1:0]      lrst_q;
  logic            scl_m_q, scl_s_q, scl_p_q;
  logic            sda_m_q, sda_s_q, sda_p_q;
  gyr_link_state_t lk_q;
  logic [3:0]      bit_cnt_q;
  logic [7:0]      shift_q;
  logic [7:0]      ptr_q;
  logic            rnw_q;
  logic            sda_rel_q;
  logic            sda_lvl_q;
  gyr_req_t        req_q;
  logic            req_tgl_q;
  logic            ack_m_q, ack_s_q, ack_p_q;
  logic [7:0]      rbuf_q;
  logic            link_rst, scl_rise, scl_fall, bus_start, bus_stop;

  // The external reset reaches the link domain through two flops.
  always_ff @(posedge link_clk_i) begin
    lrst_q <= {lrst_q[0], rst_i};
  end
  assign link_rst = lrst_q[1];

  // The pins are oversampled; the second and third stages feed edge detection.
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
    end
  end

  assign scl_rise  = scl_s_q & ~scl_p_q;
  assign scl_fall  = ~scl_s_q & scl_p_q;
  assign bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign bus_stop  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // Byte engine; it also launches every register access toward the core.
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      lk_q      <= LK_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      ptr_q     <= 8'h00;
      rnw_q     <= 1'b0;
      sda_rel_q <= 1'b1;
      req_q     <= '0;
      req_tgl_q <= 1'b0;
    end else if (bus_stop) begin
      lk_q      <= LK_IDLE;
      sda_rel_q <= 1'b1;
    end else if (bus_start) begin
      lk_q      <= LK_ADDR;
      bit_cnt_q <= 4'h0;
      sda_rel_q <= 1'b1;
    end else begin
      case (lk_q)
        LK_ADDR, LK_PTR, LK_WDATA: begin
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_s_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == 4'h8) begin
            bit_cnt_q <= 4'h0;
            sda_rel_q <= 1'b0;
            if (lk_q == LK_ADDR) begin
              if (shift_q[7:1] == DEV_ADDR) begin
                rnw_q <= shift_q[0];
                lk_q  <= LK_ADDR_ACK;
              end else begin
                sda_rel_q <= 1'b1;
                lk_q      <= LK_IDLE;
              end
            end else if (lk_q == LK_PTR) begin
              ptr_q <= shift_q;
              lk_q  <= LK_PTR_ACK;
            end else begin
              req_q     <= '{wr: 1'b1, addr: ptr_q, data: shift_q};
              req_tgl_q <= ~req_tgl_q;
              ptr_q     <= ptr_next(ptr_q);
              lk_q      <= LK_WDATA_ACK;
            end
          end
        end
        LK_PTR_ACK, LK_WDATA_ACK: begin
          if (scl_fall) begin
            sda_rel_q <= 1'b1;
            lk_q      <= LK_WDATA;
          end
        end
        LK_ADDR_ACK, LK_RDATA_ACK: begin
          // Read data is fetched while SCL is high, ahead of the bit.
          if (scl_rise && (lk_q == LK_ADDR_ACK ? rnw_q : ~sda_s_q)) begin
            req_q     <= '{wr: 1'b0, addr: ptr_q, data: 8'h00};
            req_tgl_q <= ~req_tgl_q;
            ptr_q     <= ptr_next(ptr_q);
          end else if (scl_rise && lk_q == LK_RDATA_ACK) begin
            lk_q <= LK_IDLE;
          end else if (scl_fall) begin
            if (lk_q == LK_ADDR_ACK && !rnw_q) begin
              sda_rel_q <= 1'b1;
              lk_q      <= LK_PTR;
            end else begin
              shift_q   <= rbuf_q;
              sda_rel_q <= rbuf_q[7];
              lk_q      <= LK_RDATA;
            end
          end
        end
        LK_RDATA: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == 4'h8) begin
            bit_cnt_q <= 4'h0;
            sda_rel_q <= 1'b1;
            lk_q      <= LK_RDATA_ACK;
          end else if (scl_fall) begin
            shift_q   <= {shift_q[6:0], 1'b0};
            sda_rel_q <= shift_q[6];
          end
        end
        default: begin
          sda_rel_q <= 1'b1;
          lk_q      <= LK_IDLE;
        end
      endcase
    end
  end

  // The pin only ever pulls low; the enable does the signalling.
  always_ff @(posedge link_clk_i) begin
    sda_lvl_q <= 1'b0;
  end
  assign sda_o      = sda_lvl_q;
  assign sda_oe_n_o = sda_rel_q;

  // Read answer: the acknowledge toggle is synchronised, then the stable
  // read byte is taken.
  logic       ack_tgl_q;
  logic [7:0] rdata_q;
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      {ack_m_q, ack_s_q, ack_p_q} <= 3'h0;
      rbuf_q <= 8'h00;
    end else begin
      {ack_m_q, ack_s_q, ack_p_q} <= {ack_tgl_q, ack_m_q, ack_s_q};
      if (ack_s_q ^ ack_p_q) begin
        rbuf_q <= rdata_q;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Core domain: request handshake
  // ---------------------------------------------------------------------
  logic rq_m_q, rq_s_q, rq_p_q;
  logic req_evt, wr_evt, rd_evt;

  // Only the external reset touches the handshake, so a master reset
  // never leaves a toggle pair out of step with the link.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {rq_m_q, rq_s_q, rq_p_q} <= 3'h0;
      ack_tgl_q <= 1'b0;
    end else begin
      {rq_m_q, rq_s_q, rq_p_q} <= {req_tgl_q, rq_m_q, rq_s_q};
      if (req_evt) begin
        ack_tgl_q <= ~ack_tgl_q;
      end
    end
  end
  assign req_evt = rq_s_q ^ rq_p_q;
  assign wr_evt  = req_evt & req_q.wr;
  assign rd_evt  = req_evt & ~req_q.wr;

  // ---------------------------------------------------------------------
  // Core domain: registers
  // ---------------------------------------------------------------------
  logic [7:0]  cfg_q;
  logic [7:0]  div_q;
  logic [7:0]  div_cnt_q;
  gyr_power_t  pwr_q;
  logic [2:0]  flags_q;
  gyr_sample_t data_q;
  logic        srst_q, core_rst;
  logic        pll_m_q, pll_s_q, sel_chg_q;
  logic        clk_evt, cap_evt, flag_clr;
  logic [2:0]  flag_set;

  // Master reset is a one-cycle pulse and reads back as zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= wr_evt && req_q.addr == `GYR_OFS_POWER
                && req_q.data[`GYR_PWR_RESET];
    end
  end
  assign core_rst = rst_i | srst_q;

  // Configuration; the two unused bits are never stored.
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      cfg_q <= `GYR_CFG_RESET;
      div_q <= `GYR_DIV_RESET;
    end else if (wr_evt && req_q.addr == `GYR_OFS_IRQ_CFG) begin
      cfg_q <= req_q.data & `GYR_CFG_WR_MASK;
    end else if (wr_evt && req_q.addr == `GYR_OFS_DIVIDER) begin
      div_q <= req_q.data;
    end
  end

  // Power control; clock select comes up on the oscillator.
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      pwr_q <= `GYR_PWR_RESET_VAL;
    end else if (wr_evt && req_q.addr == `GYR_OFS_POWER) begin
      pwr_q <= req_q.data[6:0];
    end
  end
  assign power_o = pwr_q;

  // A clock source change waits for the PLL; the oscillator needs none.
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      {pll_m_q, pll_s_q} <= 2'h0;
      sel_chg_q <= 1'b0;
    end else begin
      {pll_m_q, pll_s_q} <= {pll_ready_i, pll_m_q};
      if (wr_evt && req_q.addr == `GYR_OFS_POWER
          && req_q.data[2:0] != pwr_q.clk_sel) begin
        sel_chg_q <= 1'b1;
      end else if (clk_evt) begin
        sel_chg_q <= 1'b0;
      end
    end
  end
  assign clk_evt = sel_chg_q & (pll_s_q | pwr_q.clk_sel == 3'h0);

  // Sample divider; sleep freezes both the count and the data.
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      div_cnt_q <= 8'h00;
    end else if (sample_tick_i && !pwr_q.sleep) begin
      div_cnt_q <= cap_evt ? 8'h00 : div_cnt_q + 8'h01;
    end
  end
  assign cap_evt = sample_tick_i & ~pwr_q.sleep & (div_cnt_q == div_q);

  // Sample capture; an axis in standby keeps its last value.
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      data_q <= '0;
    end else if (cap_evt) begin
      data_q.temp <= sample_i.temp;
      if (!pwr_q.standby[2]) data_q.x <= sample_i.x;
      if (!pwr_q.standby[1]) data_q.y <= sample_i.y;
      if (!pwr_q.standby[0]) data_q.z <= sample_i.z;
    end
  end

  // Status flags; a new event wins over a clearing read.
  assign flag_set = {clk_evt & cfg_q[`GYR_CFG_CLK_RDY_EN], 1'b0,
                     cap_evt & cfg_q[`GYR_CFG_DATA_RDY_EN]};
  assign flag_clr = rd_evt & (cfg_q[`GYR_CFG_ANY_READ]
                    | req_q.addr == `GYR_OFS_FLAGS);
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      flags_q <= `GYR_FLAGS_RESET;
    end else begin
      flags_q <= (flags_q & ~{3{flag_clr}}) | flag_set;
    end
  end

  // Read mux; sample bytes need no pending event to be read.
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    case (a)
      `GYR_OFS_DIVIDER: reg_read = div_q;
      `GYR_OFS_IRQ_CFG: reg_read = cfg_q;
      `GYR_OFS_FLAGS:   reg_read = {5'h00, flags_q};
      `GYR_OFS_TEMP_H:  reg_read = data_q.temp[15:8];
      `GYR_OFS_TEMP_L:  reg_read = data_q.temp[7:0];
      `GYR_OFS_X_H:     reg_read = data_q.x[15:8];
      `GYR_OFS_X_L:     reg_read = data_q.x[7:0];
      `GYR_OFS_Y_H:     reg_read = data_q.y[15:8];
      `GYR_OFS_Y_L:     reg_read = data_q.y[7:0];
      `GYR_OFS_Z_H:     reg_read = data_q.z[15:8];
      `GYR_OFS_Z_L:     reg_read = data_q.z[7:0];
      `GYR_OFS_POWER:   reg_read = {1'b0, pwr_q};
      default:          reg_read = 8'h00;
    endcase
  endfunction

  // The read byte stays put until the next request, so the link may take
  // it at any time after the acknowledge toggle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (rd_evt) begin
      rdata_q <= reg_read(req_q.addr);
    end
  end

  // ---------------------------------------------------------------------
  // Core domain: interrupt pin
  // ---------------------------------------------------------------------
  logic        pulse_q;
  logic [15:0] pulse_cnt_q;
  logic        irq_lvl;

  // Pulse mode: a new event starts one pulse; events inside it merge.
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      pulse_q     <= 1'b0;
      pulse_cnt_q <= 16'h0000;
    end else if (!pulse_q && |flag_set) begin
      pulse_q     <= 1'b1;
      pulse_cnt_q <= 16'(PULSE_M1);
    end else if (pulse_q && pulse_cnt_q == 16'h0000) begin
      pulse_q <= 1'b0;
    end else if (pulse_q) begin
      pulse_cnt_q <= pulse_cnt_q - 16'h0001;
    end
  end

  assign irq_lvl = (cfg_q[`GYR_CFG_LATCH] ? |flags_q : pulse_q)
                   ^ cfg_q[`GYR_CFG_ACTIVE_LOW];

  // Open drain only ever pulls low and floats the high level.
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      irq_o      <= 1'b0;
      irq_oe_n_o <= 1'b0;
    end else begin
      irq_o      <= irq_lvl;
      irq_oe_n_o <= cfg_q[`GYR_CFG_OPEN_DRAIN] & irq_lvl;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (core_rst);

  sequence s_sel_change;
    wr_evt && req_q.addr == `GYR_OFS_POWER
      && req_q.data[2:0] != pwr_q.clk_sel && !req_q.data[7];
  endsequence

  sequence s_pll_up;
    pll_s_q && cfg_q[`GYR_CFG_CLK_RDY_EN];
  endsequence

  // The cycle after a reset shows reset pin values, not the old setting.
  a_pin_polarity: assert property (
    !$past(core_rst) && $past(cfg_q[`GYR_CFG_ACTIVE_LOW])
      && !$past(irq_lvl ^ cfg_q[`GYR_CFG_ACTIVE_LOW]) |-> irq_o == 1'b1)
    else $error("interrupt pin polarity wrong");

  a_open_drain: assert property (
    $past(cfg_q[`GYR_CFG_OPEN_DRAIN]) |-> (irq_oe_n_o == irq_o))
    else $error("open drain pin drives high");

  a_pulse_width: assert property (
    $rose(pulse_q) |-> pulse_cnt_q == 16'(PULSE_M1) ##1 pulse_q[*8])
    else $error("interrupt pulse too short");

  a_pulse_end: assert property (
    $rose(pulse_q) |-> ##[1:PULSE_CYC] !pulse_q)
    else $error("interrupt pulse too long");

  a_clear_read: assert property (
    flag_clr && flag_set == 3'h0 |=> flags_q == 3'h0)
    else $error("flags not cleared by read");

  a_sel_pending: assert property (
    s_sel_change |=> sel_chg_q)
    else $error("clock source change not held pending");

  a_clock_ready: assert property (
    (s_pll_up and sel_chg_q) |=> flags_q[`GYR_FLAG_CLK_RDY])
    else $error("clock ready flag missing");

  a_data_ready: assert property (
    cap_evt && cfg_q[`GYR_CFG_DATA_RDY_EN]
      |=> flags_q[`GYR_FLAG_DATA_RDY] && data_q.temp == $past(sample_i.temp))
    else $error("data ready flag or sample missing");

  a_no_enable: assert property (
    $rose(flags_q[`GYR_FLAG_DATA_RDY])
      |-> $past(cfg_q[`GYR_CFG_DATA_RDY_EN]))
    else $error("flag set while disabled");

  a_sleep_hold: assert property (
    pwr_q.sleep |=> $stable(data_q) && $stable(div_cnt_q))
    else $error("samples change in sleep");

  a_sample_div: assert property (
    sample_tick_i && !pwr_q.sleep && div_cnt_q != div_q |-> !cap_evt)
    else $error("capture before divider expires");

  a_latch_level: assert property (
    cfg_q[`GYR_CFG_LATCH] && |flags_q && !flag_clr && !wr_evt
      |=> ##1 (irq_o ^ $past(cfg_q[`GYR_CFG_ACTIVE_LOW])))
    else $error("latched interrupt not asserted");

endmodule
